// ---- design/slsc_pkg.sv ----
package slsc_pkg;

	// ----------------------------------------------------------------
	// Register bus geometry
	// ----------------------------------------------------------------
	localparam int SLSC_ADDR_W = 12;
	localparam int SLSC_DATA_W = 8;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [11:0] EOF_COMMA_SEL_OFS = 12'h207;
	localparam logic [11:0] LINK_STATUS_OFS = 12'h208;
	localparam logic [11:0] CHAN_PAIR_EN_OFS = 12'h209;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] EOF_COMMA_SEL_RST = 8'h00;
	localparam logic [7:0] CHAN_PAIR_EN_RST = 8'h03;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int COMMA_SEL_LSB = 0;
	localparam int COMMA_SEL_W = 2;
	localparam int ST_LINK_UP_BIT = 6;
	localparam int ST_SYNC_BIT = 5;
	localparam int ST_REALIGN_BIT = 4;
	localparam int ST_PHASE_SET_BIT = 3;
	localparam int ST_SPLL_BIT = 2;
	localparam int ST_CPLL_BIT = 0;
	localparam int CH_ONE_MODE_BIT = 2;
	localparam int CH_UPPER_BIT = 1;
	localparam int CH_LOWER_BIT = 0;
	localparam int CH_FIELD_W = 3;

	// ----------------------------------------------------------------
	// End-of-frame comma selection and 8B/10B control codes
	// ----------------------------------------------------------------
	typedef enum logic [1:0]
	{
		SLSC_COMMA_K28_7 = 2'h0,
		SLSC_COMMA_K28_1 = 2'h1,
		SLSC_COMMA_K28_5 = 2'h2,
		SLSC_COMMA_RSVD = 2'h3
	} slsc_comma_t;

	localparam logic [7:0] K28_7_CODE = 8'hFC;
	localparam logic [7:0] K28_1_CODE = 8'h3C;
	localparam logic [7:0] K28_5_CODE = 8'hBC;

	// ----------------------------------------------------------------
	// Timing and counts
	// ----------------------------------------------------------------
	localparam int SYNC_STAGES = 2;
	localparam int ASYNC_IN_N = 4;
	localparam int MF_PERIOD_CYC = 16;
	localparam int FULL_CONV = 4;

endpackage

// ---- design/slsc_eof_if.sv ----
`timescale 1ns/100ps

// Lane byte path between the register core and the frame-end marker
interface slsc_eof_if;
	import slsc_pkg::*;

	logic [1:0] comma_sel;
	logic use_8b10b;
	logic [7:0] data_in;
	logic frame_end;
	logic [7:0] data_out;
	logic k_out;

	modport core
	(
		output comma_sel,
		output use_8b10b,
		output data_in,
		output frame_end,
		input data_out,
		input k_out
	);

	modport marker
	(
		input comma_sel,
		input use_8b10b,
		input data_in,
		input frame_end,
		output data_out,
		output k_out
	);
endinterface

// ---- design/slsc_eof_marker.sv ----
`timescale 1ns/100ps

module slsc_eof_marker
	import slsc_pkg::*;
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// Lane path
	slsc_eof_if.marker eof
);

	// ----------------------------------------------------------------
	// Comma decode
	// ----------------------------------------------------------------
	logic [7:0] comma_code;
	logic [7:0] last_octet_r;
	logic [7:0] data_r;
	logic k_r;
	logic replace;

	// Reserved code falls back to the compliant character
	always_comb
	begin
		unique case (slsc_comma_t'(eof.comma_sel))
			SLSC_COMMA_K28_1: comma_code = K28_1_CODE;
			SLSC_COMMA_K28_5: comma_code = K28_5_CODE;
			default: comma_code = K28_7_CODE;
		endcase
	end

	// Only a repeat of the previous frame's last octet may be swapped
	assign replace = eof.frame_end && eof.use_8b10b && (eof.data_in == last_octet_r);

	// ----------------------------------------------------------------
	// Output stage
	// ----------------------------------------------------------------
	// Remember the true last octet, not the substituted comma
	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
			last_octet_r <= 8'h00;
		else if (eof.frame_end)
			last_octet_r <= eof.data_in;
	end

	// One cycle of latency on every byte
	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
		begin
			data_r <= 8'h00;
			k_r <= 1'b0;
		end
		else
		begin
			data_r <= replace ? comma_code : eof.data_in;
			k_r <= replace;
		end
	end

	assign eof.data_out = data_r;
	assign eof.k_out = k_r;

	AST_EOF_64B: assert property (@(posedge clock_i) disable iff (!rst_n_i) !eof.use_8b10b |=> !eof.k_out)
		else $error("comma inserted in 64b66b mode");
	AST_EOF_CODE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		replace && eof.comma_sel == 2'h1 |=> eof.k_out && eof.data_out == K28_1_CODE)
		else $error("wrong end-of-frame comma");
	AST_EOF_ONLY_REPEAT: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		eof.frame_end && eof.data_in != last_octet_r |=> !eof.k_out)
		else $error("comma replaced a fresh octet");

endmodule

// ---- design/slsc_regs.sv ----
`timescale 1ns/100ps

//Contract
// - Comma field: 0 K28.7, 1 K28.1, 2 K28.5, 3 reserved.
// - Comma replaces frame-end octet only when transport allows, not every frame.
// - Comma selection applies to 8B/10B modes only, ignored in 64B/66B.
// - Status bit 6 shows link up.
// - Status bit 5 shows live sync request: 0 asserted, 1 released.
// - Status bit 4 sets on phase realign by SYSREF; write 1 clears.
// - Status bit 3 sets on first SYSREF after enabling; write 1 clears.
// - Status bit 2 shows serializer PLL lock.
// - Status bit 0 shows converter PLL lock.
// - Channel register: single bit 2, upper pair 1, lower pair 0, reset 0x03.
// - Single-channel bit disables channels B, C and D.
// - Upper pair bit enables C and D, lower pair bit enables A and B.
// - One pair off halves converters, lanes ceil half, odd count pads tail.
module slsc_regs
	import slsc_pkg::*;
#(
	parameter int MF_PERIOD = MF_PERIOD_CYC
)
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// Register port
	input wire logic [SLSC_ADDR_W-1:0] addr_i,
	input wire logic [SLSC_DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [SLSC_DATA_W-1:0] rdata_o,
	// Link control from the device core
	input wire logic link_enable_i,
	input wire logic enc_8b10b_i,
	input wire logic link_up_i,
	input wire logic [3:0] full_lanes_i,
	// Asynchronous pins
	input wire logic sync_n_i,
	input wire logic sysref_i,
	input wire logic spll_lock_i,
	input wire logic cpll_lock_i,
	// Lane byte path
	input wire logic [7:0] lane_data_i,
	input wire logic frame_end_i,
	output logic [7:0] lane_data_o,
	output logic lane_k_o,
	// Channel configuration
	output logic [3:0] chan_enable_o,
	output logic [2:0] conv_count_o,
	output logic [3:0] lane_count_o,
	output logic tail_pad_o
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [ASYNC_IN_N-1:0] async_in;
	logic [ASYNC_IN_N-1:0] sync_q1_r;
	logic [ASYNC_IN_N-1:0] sync_q2_r;
	logic sync_n_s;
	logic sysref_s;
	logic spll_s;
	logic cpll_s;

	assign async_in = {cpll_lock_i, spll_lock_i, sysref_i, sync_n_i};

	// Two flops per pin; only the second one feeds logic
	generate
		for (genvar g = 0; g < ASYNC_IN_N; g++)
		begin : g_sync
			always_ff @(posedge clock_i)
			begin
				if (!rst_n_i)
				begin
					sync_q1_r[g] <= 1'b0;
					sync_q2_r[g] <= 1'b0;
				end
				else
				begin
					sync_q1_r[g] <= async_in[g];
					sync_q2_r[g] <= sync_q1_r[g];
				end
			end
		end
	endgenerate

	assign sync_n_s = sync_q2_r[0];
	assign sysref_s = sync_q2_r[1];
	assign spll_s = sync_q2_r[2];
	assign cpll_s = sync_q2_r[3];

	// ----------------------------------------------------------------
	// Register decode
	// ----------------------------------------------------------------
	logic sel_comma;
	logic sel_status;
	logic sel_chan;

	assign sel_comma = (addr_i == EOF_COMMA_SEL_OFS);
	assign sel_status = (addr_i == LINK_STATUS_OFS);
	assign sel_chan = (addr_i == CHAN_PAIR_EN_OFS);

	// ----------------------------------------------------------------
	// Comma selection register
	// ----------------------------------------------------------------
	logic [COMMA_SEL_W-1:0] comma_sel_r;

	// Upper bits are not stored; software is expected to write them as zero
	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
			comma_sel_r <= EOF_COMMA_SEL_RST[COMMA_SEL_W-1:0];
		else if (wr_i && sel_comma)
			comma_sel_r <= wdata_i[COMMA_SEL_LSB +: COMMA_SEL_W];
	end

	// ----------------------------------------------------------------
	// SYSREF event detection and phase tracking
	// ----------------------------------------------------------------
	logic sysref_d_r;
	logic sysref_edge;
	logic [$clog2(MF_PERIOD)-1:0] mf_cnt_r;
	logic link_en_d_r;
	logic phase_armed_r;
	logic realign_evt;
	logic phase_set_evt;

	// Edge taken from the second flop against a third, never the first
	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
			sysref_d_r <= 1'b0;
		else
			sysref_d_r <= sysref_s;
	end

	assign sysref_edge = sysref_s && !sysref_d_r;

	// Local multiframe phase; a SYSREF off phase zero shifts it
	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
			mf_cnt_r <= '0;
		else if (sysref_edge || mf_cnt_r == ($clog2(MF_PERIOD))'(MF_PERIOD - 1))
			mf_cnt_r <= '0;
		else
			mf_cnt_r <= mf_cnt_r + 1'b1;
	end

	assign realign_evt = sysref_edge && (mf_cnt_r != '0);

	// Arm on each rising link enable so the next SYSREF marks the phase
	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
		begin
			link_en_d_r <= 1'b0;
			phase_armed_r <= 1'b0;
		end
		else
		begin
			link_en_d_r <= link_enable_i;
			if (link_enable_i && !link_en_d_r)
				phase_armed_r <= 1'b1;
			else if (sysref_edge)
				phase_armed_r <= 1'b0;
		end
	end

	assign phase_set_evt = sysref_edge && phase_armed_r;

	// ----------------------------------------------------------------
	// Sticky status flags
	// ----------------------------------------------------------------
	logic realign_flag_r;
	logic phase_set_flag_r;
	logic st_wr;

	assign st_wr = wr_i && sel_status;

	// Set beats write-one-to-clear in the same cycle, so no event is lost
	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
			realign_flag_r <= 1'b0;
		else if (realign_evt)
			realign_flag_r <= 1'b1;
		else if (st_wr && wdata_i[ST_REALIGN_BIT])
			realign_flag_r <= 1'b0;
	end

	// Same policy for the multiframe phase flag
	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
			phase_set_flag_r <= 1'b0;
		else if (phase_set_evt)
			phase_set_flag_r <= 1'b1;
		else if (st_wr && wdata_i[ST_PHASE_SET_BIT])
			phase_set_flag_r <= 1'b0;
	end

	// Live bits are never stored, so writes to them have no effect
	logic [7:0] status_view;

	always_comb
	begin
		status_view = 8'h00;
		status_view[ST_LINK_UP_BIT] = link_up_i;
		status_view[ST_SYNC_BIT] = sync_n_s;
		status_view[ST_REALIGN_BIT] = realign_flag_r;
		status_view[ST_PHASE_SET_BIT] = phase_set_flag_r;
		status_view[ST_SPLL_BIT] = spll_s;
		status_view[ST_CPLL_BIT] = cpll_s;
	end

	// ----------------------------------------------------------------
	// Channel pair enable register
	// ----------------------------------------------------------------
	logic [CH_FIELD_W-1:0] channel_pair_enable_r;

	// Software must hold calibration and link off while changing this
	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
			channel_pair_enable_r <= CHAN_PAIR_EN_RST[CH_FIELD_W-1:0];
		else if (wr_i && sel_chan)
			channel_pair_enable_r <= wdata_i[CH_FIELD_W-1:0];
	end

	// ----------------------------------------------------------------
	// Channel and lane scaling
	// ----------------------------------------------------------------
	logic one_mode;
	logic upper_en;
	logic lower_en;
	logic pair_off;
	logic [3:0] half_lanes;

	assign one_mode = channel_pair_enable_r[CH_ONE_MODE_BIT];
	assign upper_en = channel_pair_enable_r[CH_UPPER_BIT];
	assign lower_en = channel_pair_enable_r[CH_LOWER_BIT];
	assign pair_off = one_mode || (upper_en != lower_en);
	assign half_lanes = (full_lanes_i >> 1) + {3'h0, full_lanes_i[0]};

	// Channel order on the bus is {D, C, B, A}
	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
			chan_enable_o <= 4'hF;
		else if (one_mode)
			chan_enable_o <= 4'h1;
		else
			chan_enable_o <= {upper_en, upper_en, lower_en, lower_en};
	end

	// Both pairs off is undefined; report zero converters then
	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
		begin
			conv_count_o <= 3'(FULL_CONV);
			lane_count_o <= 4'h0;
			tail_pad_o <= 1'b0;
		end
		else
		begin
			if (one_mode)
				conv_count_o <= 3'h1;
			else if (upper_en && lower_en)
				conv_count_o <= 3'(FULL_CONV);
			else if (pair_off)
				conv_count_o <= 3'(FULL_CONV / 2);
			else
				conv_count_o <= 3'h0;
			lane_count_o <= pair_off ? half_lanes : full_lanes_i;
			tail_pad_o <= pair_off && full_lanes_i[0];
		end
	end

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	// Data stand for exactly one cycle; unmapped addresses read zero
	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
			rdata_o <= 8'h00;
		else if (rd_i && sel_comma)
			rdata_o <= {6'h00, comma_sel_r};
		else if (rd_i && sel_status)
			rdata_o <= status_view;
		else if (rd_i && sel_chan)
			rdata_o <= {5'h00, channel_pair_enable_r};
		else
			rdata_o <= 8'h00;
	end

	// ----------------------------------------------------------------
	// Frame-end comma insertion
	// ----------------------------------------------------------------
	slsc_eof_if eof_bus ();

	assign eof_bus.comma_sel = comma_sel_r;
	assign eof_bus.use_8b10b = enc_8b10b_i;
	assign eof_bus.data_in = lane_data_i;
	assign eof_bus.frame_end = frame_end_i;

	slsc_eof_marker u_marker
	(
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.eof(eof_bus.marker)
	);

	assign lane_data_o = eof_bus.data_out;
	assign lane_k_o = eof_bus.k_out;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	AST_LINK_UP_READ: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		rd_i && sel_status |=> rdata_o[ST_LINK_UP_BIT] == $past(link_up_i))
		else $error("link up bit mismatch");
	AST_SYNC_READ: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		rd_i && sel_status |=> rdata_o[ST_SYNC_BIT] == $past(sync_n_s))
		else $error("sync bit mismatch");
	AST_REALIGN_SET: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		realign_evt |=> realign_flag_r)
		else $error("realign flag not set");
	AST_REALIGN_CLEAR: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		st_wr && wdata_i[ST_REALIGN_BIT] && !realign_evt |=> !realign_flag_r)
		else $error("realign flag not cleared");
	AST_PHASE_SET: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		link_enable_i && !link_en_d_r ##1 (!sysref_edge)[*2] ##1 sysref_edge
		|=> phase_set_flag_r)
		else $error("phase flag missed first sysref");
	AST_PLL_READ: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		rd_i && sel_status |=> rdata_o[ST_SPLL_BIT] == $past(spll_s) && rdata_o[ST_CPLL_BIT] == $past(cpll_s))
		else $error("pll lock bits mismatch");
	AST_CPLL_LIVE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		$past(rst_n_i) && $past(rst_n_i, 2) |-> status_view[ST_CPLL_BIT] == $past(cpll_lock_i, 2))
		else $error("converter lock not live");
	AST_CHEN_RESET: assert property (@(posedge clock_i)
		!rst_n_i |=> channel_pair_enable_r == CHAN_PAIR_EN_RST[CH_FIELD_W-1:0])
		else $error("channel register reset wrong");
	AST_ONE_MODE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		one_mode |=> chan_enable_o == 4'h1 && conv_count_o == 3'h1)
		else $error("single channel mode wrong");
	AST_PAIRS: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		!one_mode |=> chan_enable_o[3:2] == {2{$past(upper_en)}} && chan_enable_o[1:0] == {2{$past(lower_en)}})
		else $error("pair enables wrong");
	AST_LANES: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		pair_off && !one_mode |=> lane_count_o == 4'(({1'b0, $past(full_lanes_i)} + 5'h01) >> 1)
		&& tail_pad_o == $past(full_lanes_i[0]))
		else $error("lane scaling wrong");
	AST_RSVD_ZERO: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		rd_i && sel_status |=> rdata_o[7] == 1'b0 && rdata_o[1] == 1'b0)
		else $error("reserved status bits not zero");
	AST_SET_WINS: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		phase_set_evt && st_wr && wdata_i[ST_PHASE_SET_BIT] |=> phase_set_flag_r)
		else $error("clear beat a set");
	AST_COMMA_LOW: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		wr_i && sel_comma |=> comma_sel_r == $past(wdata_i[1:0]))
		else $error("comma field not stored");

endmodule

// ---- verif/slsc_rx_model.sv ----
`timescale 1ns/100ps

// ----------------------------------------------------------------
// Far-end receiver model
// ----------------------------------------------------------------
module slsc_rx_model
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// Control from the bench
	input wire logic sync_req_i,
	// Lane from the device
	input wire logic [7:0] lane_data_i,
	input wire logic lane_k_i,
	// Towards the device and the bench
	output logic sync_n_o,
	output logic [7:0] comma_cnt_o
);
	// Sync request is an active-low level, held as long as the bench asks
	assign sync_n_o = ~sync_req_i;

	// Count frame-end commas; only a K28 control octet counts, so a bad code shows up
	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
			comma_cnt_o <= 8'h00;
		else if (lane_k_i && lane_data_i[4:0] == 5'h1C)
			comma_cnt_o <= comma_cnt_o + 8'h01;
	end
endmodule

// ---- verif/tb_top.sv ----
`timescale 1ns/100ps

module tb_top;
	import slsc_pkg::*;

	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic clock_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [SLSC_ADDR_W-1:0] addr = 12'h000;
	logic [SLSC_DATA_W-1:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [SLSC_DATA_W-1:0] rdata;
	logic link_en = 1'b0;
	logic enc8 = 1'b1;
	logic link_up = 1'b0;
	logic [3:0] full_lanes = 4'h8;
	logic sync_req = 1'b0;
	logic sync_n;
	logic sysref = 1'b0;
	logic spll = 1'b0;
	logic cpll = 1'b0;
	logic [7:0] lane_d = 8'h00;
	logic fe = 1'b0;
	logic [7:0] lane_q;
	logic lane_k;
	logic [3:0] chan_en;
	logic [2:0] conv_cnt;
	logic [3:0] lane_cnt;
	logic tail;
	logic [7:0] comma_cnt;
	int error_cnt = 0;
	int n_tests = 0;
	// Reserved code falls back to the standard comma
	logic [7:0] codes [4] = '{K28_7_CODE, K28_1_CODE, K28_5_CODE, K28_7_CODE};

	// ----------------------------------------------------------------
	// Device and far end
	// ----------------------------------------------------------------
	// Short multiframe keeps the realignment test brief
	slsc_regs #(.MF_PERIOD(4)) uut
	(
		.clock_i(clock_i), .rst_n_i(rst_n_i),
		.addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
		.link_enable_i(link_en), .enc_8b10b_i(enc8), .link_up_i(link_up), .full_lanes_i(full_lanes),
		.sync_n_i(sync_n), .sysref_i(sysref), .spll_lock_i(spll), .cpll_lock_i(cpll),
		.lane_data_i(lane_d), .frame_end_i(fe), .lane_data_o(lane_q), .lane_k_o(lane_k),
		.chan_enable_o(chan_en), .conv_count_o(conv_cnt), .lane_count_o(lane_cnt), .tail_pad_o(tail)
	);

	slsc_rx_model rx
	(
		.clock_i(clock_i), .rst_n_i(rst_n_i), .sync_req_i(sync_req),
		.lane_data_i(lane_q), .lane_k_i(lane_k), .sync_n_o(sync_n), .comma_cnt_o(comma_cnt)
	);

	// Clock at 50 MHz
	initial
	begin
		forever #10 clock_i = ~clock_i;
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge clock_i);
	endtask

	task automatic finish_test();
		if (error_cnt == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp)
		begin
			$display("mismatch %s expected %h seen %h", name, exp, got);
			error_cnt++;
		end
	endtask

	// One-cycle write strobe, released at the edge that takes it
	task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
		@(posedge clock_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock_i);
		wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, so look there
	task automatic rd_chk(input logic [11:0] a, input logic [7:0] mask, input logic [7:0] exp);
		@(posedge clock_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock_i);
		rd <= 1'b0;
		#1;
		chk("rdata", exp, rdata & mask);
	endtask

	// One frame-end octet; the lane output lags by one cycle
	task automatic octet(input logic [7:0] d, input logic [7:0] exp_d, input logic exp_k);
		@(posedge clock_i);
		lane_d <= d;
		fe <= 1'b1;
		@(posedge clock_i);
		fe <= 1'b0;
		#1;
		chk("lane_data", exp_d, lane_q);
		chk("lane_k", {7'h00, exp_k}, {7'h00, lane_k});
	endtask

	task automatic chan_chk(input logic [7:0] w, input logic [3:0] ce, input logic [2:0] cc,
		input logic [3:0] lc, input logic tp);
		wr_reg(CHAN_PAIR_EN_OFS, w);
		tick(2);
		#1;
		chk("chan_enable", {4'h0, ce}, {4'h0, chan_en});
		chk("conv_count", {5'h00, cc}, {5'h00, conv_cnt});
		chk("lane_count", {4'h0, lc}, {4'h0, lane_cnt});
		chk("tail_pad", {7'h00, tp}, {7'h00, tail});
		rd_chk(CHAN_PAIR_EN_OFS, 8'hFF, w);
	endtask

	// SYSREF pulse long enough to pass the pin synchroniser
	task automatic sref_pulse();
		@(posedge clock_i);
		sysref <= 1'b1;
		tick(2);
		sysref <= 1'b0;
		tick(3);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		tick(8);
		rst_n_i <= 1'b1;
		tick(3);
		// Reset values, unmapped address
		rd_chk(EOF_COMMA_SEL_OFS, 8'hFF, EOF_COMMA_SEL_RST);
		rd_chk(CHAN_PAIR_EN_OFS, 8'hFF, CHAN_PAIR_EN_RST);
		rd_chk(LINK_STATUS_OFS, 8'hFF, 8'h20);
		rd_chk(12'h20A, 8'hFF, 8'h00);
		chk("chan_enable", 8'h0F, {4'h0, chan_en});
		chk("conv_count", 8'h04, {5'h00, conv_cnt});
		// Live status bits follow the pins both ways
		@(posedge clock_i);
		link_up <= 1'b1;
		spll <= 1'b1;
		tick(4);
		rd_chk(LINK_STATUS_OFS, 8'hE7, 8'h64);
		@(posedge clock_i);
		link_up <= 1'b0;
		sync_req <= 1'b1;
		spll <= 1'b0;
		cpll <= 1'b1;
		tick(4);
		rd_chk(LINK_STATUS_OFS, 8'hE7, 8'h01);
		wr_reg(LINK_STATUS_OFS, 8'hE6);
		rd_chk(LINK_STATUS_OFS, 8'hE7, 8'h01);
		// Every comma code, link disabled, reserved bits zero
		for (int c = 0; c < 4; c++)
		begin
			wr_reg(EOF_COMMA_SEL_OFS, 8'(c));
			rd_chk(EOF_COMMA_SEL_OFS, 8'hFF, 8'(c));
			octet(8'(8'h10 + c), 8'(8'h10 + c), 1'b0);
			octet(8'(8'h10 + c), codes[c], 1'b1);
		end
		octet(8'h44, 8'h44, 1'b0);
		@(posedge clock_i);
		enc8 <= 1'b0;
		octet(8'h44, 8'h44, 1'b0);
		@(posedge clock_i);
		enc8 <= 1'b1;
		// Alignment flags: first SYSREF after enable, then an off-phase one
		@(posedge clock_i);
		link_en <= 1'b1;
		sref_pulse();
		rd_chk(LINK_STATUS_OFS, 8'h08, 8'h08);
		wr_reg(LINK_STATUS_OFS, 8'h18);
		sref_pulse();
		rd_chk(LINK_STATUS_OFS, 8'h18, 8'h10);
		wr_reg(LINK_STATUS_OFS, 8'h18);
		rd_chk(LINK_STATUS_OFS, 8'h18, 8'h00);
		// A clearing write in the very cycle of the phase event leaves the flag set
		@(posedge clock_i);
		link_en <= 1'b0;
		@(posedge clock_i);
		link_en <= 1'b1;
		sysref <= 1'b1;
		tick(1);
		wr_reg(LINK_STATUS_OFS, 8'h08);
		sysref <= 1'b0;
		rd_chk(LINK_STATUS_OFS, 8'h08, 8'h08);
		// Channel layouts, link stopped first, never all off
		@(posedge clock_i);
		link_en <= 1'b0;
		full_lanes <= 4'h5;
		chan_chk(8'h05, 4'h1, 3'h1, 4'h3, 1'b1);
		chan_chk(8'h02, 4'hC, 3'h2, 4'h3, 1'b1);
		chan_chk(8'h01, 4'h3, 3'h2, 4'h3, 1'b1);
		chan_chk(8'h03, 4'hF, 3'h4, 4'h5, 1'b0);
		// Far end saw exactly one comma per code
		chk("comma_cnt", 8'h04, comma_cnt);
		finish_test();
	end

	// Watchdog: a hang counts as a mismatch
	initial
	begin
		tick(20000);
		error_cnt++;
		finish_test();
	end
endmodule
